// file: aics_top.sv
// Top: AHB-Lite register file, sample alternation and mux/clock control outputs
//
// Function
// - Auto-sample time applies only with trigger source 111 and group 0.
// - Divider ignored when internal RC conversion clock is chosen.
// - Buffer length codes 000..111 give 1..128 words.
// - Aux sample-A select clear routes inputs 0,1,2 to channels 1..3.
// - Aux sample-A select set routes comparators 1..3 to channels 1..3.
// - In twelve-bit mode aux sample-A positive select reads zero.
// - Primary code 11111 leaves channel 0 positive input open.
// - Primary code 11110 selects the temperature diode.
// - Primary codes 11000..11010 select comparators 1..3.
// - Primary codes 00000..01111 select analog inputs 0..15; others reserved.
// - Low scan bit x includes analog input x in the scan.
// - All low scan bits writable; missing pins convert low reference.
// - All implemented high scan bits writable; missing inputs convert low reference (high scan bits here only drive scanInternal, no low-reference path).
// - Unimplemented bits read zero and ignore writes.
// - Buffer length applies per analog input.
// - Alternate mode uses sample A then B alternately, else always A.
//
// The AHB-Lite slave port and the address map were left to the implementer.
module aics_top
   import aics_pkg::*;
#(
   parameter logic [15:0] PIN_PRESENT = 16'hFFFF
)
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Converter core events
   input  wire logic        sampleDone,
   // Converter control
   output logic             convTick,
   output logic [4:0]       sampleTime,
   output logic             sampleTimeValid,
   output logic             dmaEnable,
   output logic [7:0]       dmaWordsPerInput,
   // Primary channel routing
   output aics_route_t      primaryKind,
   output logic [3:0]       primaryIndex,
   output logic             primaryNeg,
   // Aux channel routing
   output logic             auxFromComparator,
   output logic [1:0]       auxNegSelect,
   // Scan
   output logic [15:0]      scanPins,
   output logic [15:0]      scanLowRef,
   output logic [4:0]       scanInternal,
   output logic             sampleB
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [15:0] clockSample;
      logic [15:0] dmaConfig;
      logic [15:0] auxSelect;
      logic [15:0] priSelect;
      logic [15:0] scanHigh;
      logic [15:0] scanLow;
      logic [15:0] ctrl;
      logic        phaseB;
      logic        wrPend;
      logic [7:0]  wrAddr;
      logic [31:0] rdata;
      logic        sampleTimeValid;
      logic [4:0]  sampleTime;
      logic        dmaEnable;
      logic [7:0]  dmaWords;
      aics_route_t priKind;
      logic [3:0]  priIndex;
      logic        priNeg;
      logic        auxCmp;
      logic [1:0]  auxNeg;
      logic [15:0] scanPins;
      logic [15:0] scanLowRef;
      logic [4:0]  scanInt;
   } aics_state_t;

   aics_state_t st, next_st;
   aics_route_t routeKind;
   logic [3:0]  routeIndex;
   logic [4:0]  priCode;
   logic        addrPhase;
   logic [15:0] auxRead;
   logic [15:0] rdVal;
   logic [15:0] wdat;
   logic        useRc;

   // ----------------------------------------
   // Submodules
   // ----------------------------------------
   assign useRc = st.clockSample[CLK_SRC_BIT];

   aics_clkdiv u_div (
      .mclk     (mclk),
      .rst      (rst),
      .enable   (!useRc),
      .divider  (st.clockSample[7:0]),
      .convTick (convTick)
   );

   aics_route u_route (
      .code  (priCode),
      .kind  (routeKind),
      .index (routeIndex)
   );

   assign priCode = st.phaseB ? st.priSelect[PRI_POS_B_LSB +: 5]
                              : st.priSelect[PRI_POS_A_LSB +: 5];

   // Sample-A aux positive select is unimplemented in twelve-bit mode
   assign auxRead = st.ctrl[CTRL_TWELVE_BIT] ?
                    (st.auxSelect & ~(16'h0001 << AUX_POS_A_BIT)) : st.auxSelect;

   assign addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ);
   assign wdat      = hwdata[15:0];

   always_comb begin
      case (haddr)
         ADDR_CLOCK_SAMPLE: rdVal = st.clockSample;
         ADDR_DMA_CONFIG:   rdVal = st.dmaConfig;
         ADDR_AUX_SELECT:   rdVal = auxRead;
         ADDR_PRI_SELECT:   rdVal = st.priSelect;
         ADDR_SCAN_HIGH:    rdVal = st.scanHigh;
         ADDR_SCAN_LOW:     rdVal = st.scanLow;
         ADDR_CTRL:         rdVal = st.ctrl;
         ADDR_STATUS:       rdVal = {15'h0000, st.phaseB};
         default:           rdVal = 16'h0000;
      endcase
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_st = st;
      // Bus: read data captured in address phase, write applied in data phase
      if (addrPhase && !hwrite) begin
         next_st.rdata = {16'h0000, rdVal};
      end
      next_st.wrPend = addrPhase && hwrite && (hsize == HSIZE_WORD);
      next_st.wrAddr = haddr;
      if (st.wrPend) begin
         case (st.wrAddr)
            ADDR_CLOCK_SAMPLE: next_st.clockSample = wdat & MASK_CLOCK_SAMPLE;
            ADDR_DMA_CONFIG:   next_st.dmaConfig   = wdat & MASK_DMA_CONFIG;
            ADDR_AUX_SELECT:   next_st.auxSelect   = wdat & MASK_AUX_SELECT;
            ADDR_PRI_SELECT:   next_st.priSelect   = wdat & MASK_PRI_SELECT;
            ADDR_SCAN_HIGH:    next_st.scanHigh    = wdat & MASK_SCAN_HIGH;
            ADDR_SCAN_LOW:     next_st.scanLow     = wdat & MASK_SCAN_LOW;
            ADDR_CTRL:         next_st.ctrl        = wdat & MASK_CTRL;
            default:           next_st.ctrl        = st.ctrl;
         endcase
      end
      // Sample alternation
      if (!st.ctrl[CTRL_ALT_BIT]) begin
         next_st.phaseB = 1'b0;
      end else if (sampleDone) begin
         next_st.phaseB = !st.phaseB;
      end
      // Derived outputs
      next_st.sampleTimeValid = (st.ctrl[CTRL_TRIG_LSB +: 3] == TRIG_AUTO)
                                && !st.ctrl[CTRL_GROUP_BIT];
      next_st.sampleTime = next_st.sampleTimeValid ?
                           st.clockSample[SAMPLE_TIME_LSB +: 5] : 5'h00;
      next_st.dmaEnable = st.dmaConfig[DMA_EN_BIT];
      // Length is per input; unused when results stay in own buffer
      next_st.dmaWords = st.dmaConfig[DMA_EN_BIT] ?
                         (8'h01 << st.dmaConfig[2:0]) : 8'h00;
      next_st.priKind  = routeKind;
      next_st.priIndex = routeIndex;
      next_st.priNeg   = st.phaseB ? st.priSelect[PRI_NEG_B_BIT] : st.priSelect[PRI_NEG_A_BIT];
      next_st.auxCmp   = st.phaseB ? st.auxSelect[AUX_POS_B_BIT]
                                   : auxRead[AUX_POS_A_BIT];
      next_st.auxNeg   = st.phaseB ? st.auxSelect[10:9] : st.auxSelect[2:1];
      // Missing pins still scan, converting the low reference instead
      next_st.scanPins   = st.scanLow & PIN_PRESENT;
      next_st.scanLowRef = st.scanLow & ~PIN_PRESENT;
      next_st.scanInt    = {st.scanHigh[15], st.scanHigh[14], st.scanHigh[10],
                            st.scanHigh[9], st.scanHigh[8]};
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign hrdata            = st.rdata;
   assign hreadyout         = 1'b1;
   assign hresp             = 1'b0;
   assign sampleTime        = st.sampleTime;
   assign sampleTimeValid   = st.sampleTimeValid;
   assign dmaEnable         = st.dmaEnable;
   assign dmaWordsPerInput  = st.dmaWords;
   assign primaryKind       = st.priKind;
   assign primaryIndex      = st.priIndex;
   assign primaryNeg        = st.priNeg;
   assign auxFromComparator = st.auxCmp;
   assign auxNegSelect      = st.auxNeg;
   assign scanPins          = st.scanPins;
   assign scanLowRef        = st.scanLowRef;
   assign scanInternal      = st.scanInt;
   assign sampleB           = st.phaseB;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_sample_gate: assert property (@(posedge mclk) disable iff (rst)
      sampleTimeValid |-> $past(st.ctrl[CTRL_TRIG_LSB +: 3]) == TRIG_AUTO)
      else $error("sample time valid without auto trigger");
   a_rc_stops_div: assert property (@(posedge mclk) disable iff (rst)
      useRc [*3] |-> !convTick)
      else $error("divider ticks while RC clock selected");
   a_dma_words: assert property (@(posedge mclk) disable iff (rst)
      $past(st.dmaConfig[DMA_EN_BIT])
      |-> dmaWordsPerInput == (8'h01 << $past(st.dmaConfig[2:0])))
      else $error("dma words mismatch");
   a_dma_off: assert property (@(posedge mclk) disable iff (rst)
      !$past(st.dmaConfig[DMA_EN_BIT]) |-> dmaWordsPerInput == 8'h00)
      else $error("dma length used while disabled");
   a_twelve_aux: assert property (@(posedge mclk) disable iff (rst)
      (addrPhase && !hwrite && haddr == ADDR_AUX_SELECT && st.ctrl[CTRL_TWELVE_BIT])
      |=> !hrdata[AUX_POS_A_BIT])
      else $error("aux select A visible in twelve-bit mode");
   a_unimpl_zero: assert property (@(posedge mclk) disable iff (rst)
      (st.dmaConfig & ~MASK_DMA_CONFIG) == 16'h0000
      && (st.scanHigh & ~MASK_SCAN_HIGH) == 16'h0000)
      else $error("unimplemented bit set");
   a_alt_hold: assert property (@(posedge mclk) disable iff (rst)
      !st.ctrl[CTRL_ALT_BIT] |=> !sampleB)
      else $error("sample B used without alternate mode");
   a_alt_toggle: assert property (@(posedge mclk) disable iff (rst)
      (st.ctrl[CTRL_ALT_BIT] && sampleDone) |=> sampleB != $past(sampleB))
      else $error("sample phase did not toggle");
   a_open_route: assert property (@(posedge mclk) disable iff (rst)
      (priCode == SEL_OPEN) |=> primaryKind == ROUTE_OPEN)
      else $error("open code not routed open");
   a_scan_split: assert property (@(posedge mclk) disable iff (rst)
      (scanPins | scanLowRef) == $past(st.scanLow))
      else $error("scan bit lost");

   c_alt_mode: cover property (@(posedge mclk) sampleB ##1 !sampleB);
   c_dma_max: cover property (@(posedge mclk) dmaWordsPerInput == 8'h80);
   c_temp_sel: cover property (@(posedge mclk) primaryKind == ROUTE_TEMP);
   c_sample_valid: cover property (@(posedge mclk) sampleTimeValid);
endmodule

// file: aics_pkg.sv
// Package: register map, field layout and encodings of the converter input/clock config block
package aics_pkg;

   // ----------------------------------------
   // Register byte addresses
   // ----------------------------------------
   localparam logic [7:0] ADDR_CLOCK_SAMPLE = 8'h00;
   localparam logic [7:0] ADDR_DMA_CONFIG   = 8'h04;
   localparam logic [7:0] ADDR_AUX_SELECT   = 8'h08;
   localparam logic [7:0] ADDR_PRI_SELECT   = 8'h0C;
   localparam logic [7:0] ADDR_SCAN_HIGH    = 8'h10;
   localparam logic [7:0] ADDR_SCAN_LOW     = 8'h14;
   localparam logic [7:0] ADDR_CTRL         = 8'h18;
   localparam logic [7:0] ADDR_STATUS       = 8'h1C;

   // ----------------------------------------
   // Writable bit masks
   // ----------------------------------------
   localparam logic [15:0] MASK_CLOCK_SAMPLE = 16'h9FFF;
   localparam logic [15:0] MASK_DMA_CONFIG   = 16'h0107;
   localparam logic [15:0] MASK_AUX_SELECT   = 16'h0707;
   localparam logic [15:0] MASK_PRI_SELECT   = 16'h9F9F;
   localparam logic [15:0] MASK_SCAN_HIGH    = 16'hC700;
   localparam logic [15:0] MASK_SCAN_LOW     = 16'hFFFF;
   localparam logic [15:0] MASK_CTRL         = 16'h0F03;
   localparam logic [15:0] REG_RESET         = 16'h0000;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int CLK_SRC_BIT      = 15;
   localparam int SAMPLE_TIME_LSB  = 8;
   localparam int DMA_EN_BIT       = 8;
   localparam int AUX_POS_A_BIT    = 0;
   localparam int AUX_POS_B_BIT    = 8;
   localparam int PRI_POS_A_LSB    = 0;
   localparam int PRI_POS_B_LSB    = 8;
   localparam int PRI_NEG_A_BIT    = 7;
   localparam int PRI_NEG_B_BIT    = 15;
   localparam int CTRL_TWELVE_BIT  = 0;
   localparam int CTRL_ALT_BIT     = 1;
   localparam int CTRL_TRIG_LSB    = 8;
   localparam int CTRL_GROUP_BIT   = 11;

   // ----------------------------------------
   // Codes
   // ----------------------------------------
   localparam logic [2:0] TRIG_AUTO        = 3'h7;
   localparam logic [4:0] SEL_OPEN         = 5'h1F;
   localparam logic [4:0] SEL_TEMP         = 5'h1E;
   localparam logic [4:0] SEL_COMPARATOR_ONE_OUTPUT         = 5'h18;
   localparam logic [4:0] SEL_CMP3         = 5'h1A;
   localparam logic [4:0] SEL_LAST_PIN     = 5'h0F;

   // Primary positive route kinds
   typedef enum logic [2:0] {
      ROUTE_PIN  = 3'b000,
      ROUTE_CMP  = 3'b001,
      ROUTE_TEMP = 3'b010,
      ROUTE_OPEN = 3'b011,
      ROUTE_RSVD = 3'b100
   } aics_route_t;

   // AHB transfer codes
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic [2:0] HSIZE_WORD    = 3'b010;
endpackage

// file: aics_clkdiv.sv
// Conversion clock divider: tick every divider+1 peripheral clocks
module aics_clkdiv
   import aics_pkg::*;
(
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // Control
   input  wire logic       enable,
   input  wire logic [7:0] divider,
   // Output
   output logic            convTick
);
   typedef struct packed {
      logic [7:0] count;
      logic       tick;
   } aics_div_t;

   aics_div_t st, next_st;

   always_comb begin
      next_st = st;
      next_st.tick = 1'b0;
      if (!enable) begin
         next_st.count = 8'h00;
      end else if (st.count >= divider) begin
         next_st.count = 8'h00;
         next_st.tick  = 1'b1;
      end else begin
         next_st.count = st.count + 8'h01;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign convTick = st.tick;

   // Divide by one ticks every cycle, so only ratios above one leave a gap
   a_tick_period: assert property (@(posedge mclk) disable iff (rst)
      (convTick && enable && $stable(divider) && divider != 8'h00)
      |-> ##1 !convTick [*1])
      else $error("tick period shorter than expected");
endmodule

// file: aics_route.sv
// Primary positive select decoder
module aics_route
   import aics_pkg::*;
(
   // Select code
   input  wire logic [4:0] code,
   // Decoded route
   output aics_route_t     kind,
   output logic [3:0]      index
);
   always_comb begin
      index = 4'h0;
      if (code == SEL_OPEN) begin
         kind = ROUTE_OPEN;
      end else if (code == SEL_TEMP) begin
         kind = ROUTE_TEMP;
      end else if (code >= SEL_COMPARATOR_ONE_OUTPUT && code <= SEL_CMP3) begin
         kind  = ROUTE_CMP;
         index = 4'(code - SEL_COMPARATOR_ONE_OUTPUT + 5'h01);
      end else if (code <= SEL_LAST_PIN) begin
         kind  = ROUTE_PIN;
         index = code[3:0];
      end else begin
         kind = ROUTE_RSVD;
      end
   end
endmodule

// file: aics_tb.sv
// Self-checking testbench for the converter input select and clock config block
module testbench
   import aics_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------
   // Signals and reference model state
   // ----------------------------------------
   // Pins 8..11 absent so the low-reference path is exercised
   localparam logic [15:0] PINS = 16'hF0FF;
   localparam logic [15:0] MASKS [8] = '{MASK_CLOCK_SAMPLE, MASK_DMA_CONFIG, MASK_AUX_SELECT,
      MASK_PRI_SELECT, MASK_SCAN_HIGH, MASK_SCAN_LOW, MASK_CTRL, 16'h0000};
   logic              mclk, rst, hsel, hwrite, hreadyout, hresp, sampleDone, convTick;
   logic              sampleTimeValid, dmaEnable, primaryNeg, auxFromComparator, sampleB;
   logic [7:0]        haddr, dmaWordsPerInput;
   logic [1:0]        htrans, auxNegSelect;
   logic [2:0]        hsize;
   logic [31:0]       hwdata, hrdata, v;
   logic [4:0]        sampleTime, scanInternal;
   logic [3:0]        primaryIndex;
   logic [15:0]       scanPins, scanLowRef;
   aics_route_t       primaryKind;
   int                regs [8];
   int                phaseB, checks, miscompares;

   aics_top #(.PIN_PRESENT(PINS)) uut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sampleDone(sampleDone),
      .convTick(convTick), .sampleTime(sampleTime), .sampleTimeValid(sampleTimeValid),
      .dmaEnable(dmaEnable), .dmaWordsPerInput(dmaWordsPerInput), .primaryKind(primaryKind),
      .primaryIndex(primaryIndex), .primaryNeg(primaryNeg), .auxFromComparator(auxFromComparator),
      .auxNegSelect(auxNegSelect), .scanPins(scanPins), .scanLowRef(scanLowRef),
      .scanInternal(scanInternal), .sampleB(sampleB));

   always #20 mclk = ~mclk;

   // ----------------------------------------
   // Reporting
   // ----------------------------------------
   task automatic final_report;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // ----------------------------------------
   // Bus master and model
   // ----------------------------------------
   // Master waits on hready in both phases even though this slave never stalls
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      int n;
      @(posedge mclk);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      hsize  <= HSIZE_WORD;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      htrans <= 2'b00;
      hwdata <= wd;
      do begin
         @(posedge mclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 40);
      rd = hrdata;
      if (n >= 40) begin
         miscompares++;
         final_report();
      end
   endtask

   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      ahb(1'b1, a, d, rd);
      if (a < 8'h20) regs[a[4:2]] = int'(d[15:0] & MASKS[a[4:2]]);
      if (a == ADDR_CTRL && !d[1]) phaseB = 0;
   endtask

   function automatic logic [31:0] expRead(input logic [7:0] a);
      logic [31:0] r;
      r = (a < 8'h20) ? 32'(regs[a[4:2]]) : 32'h0000_0000;
      if (a == ADDR_AUX_SELECT && regs[6][0]) r[0] = 1'b0;
      if (a == ADDR_STATUS) r[0] = phaseB[0];
      return r;
   endfunction

   task automatic rchk(input logic [7:0] a);
      logic [31:0] rd;
      ahb(1'b0, a, 32'h0000_0000, rd);
      chk($sformatf("read %h", a), expRead(a), rd);
      chk("hresp", 32'h0000_0000, hresp);
   endtask

   // Derived outputs lag a write by one extra cycle
   task automatic settle;
      repeat (2) @(posedge mclk);
      #1;
   endtask

   task automatic pulse;
      @(posedge mclk);
      sampleDone <= 1'b1;
      @(posedge mclk);
      sampleDone <= 1'b0;
      if (regs[6][1]) phaseB ^= 1;
      settle();
   endtask

   task automatic outs;
      logic [15:0] cs, dm, ax, pr, ct, hi, lo;
      logic [4:0]  code;
      logic [2:0]  kind;
      logic        hit;
      cs = regs[0][15:0];
      dm = regs[1][15:0];
      ax = regs[2][15:0];
      pr = regs[3][15:0];
      hi = regs[4][15:0];
      lo = regs[5][15:0];
      ct = regs[6][15:0];
      hit = ct[10:8] == 3'h7 && !ct[11];
      chk("sampleTime", hit ? cs[12:8] : 5'h00, sampleTime);
      chk("sampleTimeValid", hit, sampleTimeValid);
      chk("dmaEnable", dm[8], dmaEnable);
      chk("dmaWords", dm[8] ? 32'h1 << dm[2:0] : 0, dmaWordsPerInput);
      code = phaseB ? pr[12:8] : pr[4:0];
      kind = ROUTE_RSVD;
      if (code <= 5'h0F) kind = ROUTE_PIN;
      if (code >= 5'h18 && code <= 5'h1A) kind = ROUTE_CMP;
      if (code == 5'h1E) kind = ROUTE_TEMP;
      if (code == 5'h1F) kind = ROUTE_OPEN;
      chk("primaryKind", kind, primaryKind);
      if (kind == ROUTE_PIN) chk("primaryIndex", code, primaryIndex);
      if (kind == ROUTE_CMP) chk("primaryIndex", code - 5'h17, primaryIndex);
      chk("primaryNeg", phaseB ? pr[15] : pr[7], primaryNeg);
      chk("auxFromCmp", phaseB ? ax[8] : (ax[0] && !ct[0]), auxFromComparator);
      chk("auxNeg", phaseB ? ax[10:9] : ax[2:1], auxNegSelect);
      chk("scanPins", lo & PINS, scanPins);
      chk("scanLowRef", lo & ~PINS, scanLowRef);
      chk("scanInternal", {hi[15:14], hi[10:8]}, scanInternal);
      chk("sampleB", phaseB[0], sampleB);
   endtask

   // Ticks counted over a bounded window; fewer than three fails unless none are expected (d < 0)
   task automatic tickchk(input int d);
      int hits[$];
      for (int n = 0; n < 300 && hits.size() < 3; n++) begin
         @(posedge mclk);
         #1;
         if (convTick === 1'b1) hits.push_back(n);
      end
      if (d < 0) chk("tickCount", 0, hits.size());
      else if (hits.size() < 3) chk("tickCount", 3, hits.size());
      else begin
         chk("tickGap", d + 1, hits[1] - hits[0]);
         chk("tickGap", d + 1, hits[2] - hits[1]);
      end
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      int d;
      mclk = 1'b0;
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h0;
      hwdata = 32'h0000_0000;
      sampleDone = 1'b0;
      foreach (regs[i]) regs[i] = 0;
      void'($urandom(25));
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      settle();
      outs();
      for (int a = 0; a <= 32; a += 4) rchk(8'(a));
      $display("test reset finished");
      for (int r = 0; r < 6; r++) begin
         for (int a = 0; a <= 32; a += 4) begin
            v = $urandom();
            if (a == 24) v[0] = 1'b0;
            wreg(8'(a), v);
         end
         for (int a = 0; a <= 32; a += 4) rchk(8'(a));
         settle();
         outs();
      end
      wreg(ADDR_AUX_SELECT, 32'h0000_0707);
      wreg(ADDR_CTRL, 32'h0000_0001);
      settle();
      outs();
      rchk(ADDR_AUX_SELECT);
      wreg(ADDR_CTRL, 32'h0000_0000);
      rchk(ADDR_AUX_SELECT);
      $display("test registers finished");
      wreg(ADDR_CLOCK_SAMPLE, 32'h0000_1503);
      for (int t = 0; t < 16; t++) begin
         wreg(ADDR_CTRL, t << 8);
         settle();
         outs();
      end
      for (int c = 0; c < 16; c++) begin
         wreg(ADDR_DMA_CONFIG, ((c & 8) << 5) | (c & 7));
         settle();
         outs();
      end
      for (int c = 0; c < 32; c++) begin
         wreg(ADDR_PRI_SELECT, ((31 - c) << 8) | c | ((c & 1) << 15) | ((c & 2) << 6));
         settle();
         outs();
      end
      $display("test decode finished");
      wreg(ADDR_PRI_SELECT, 32'h0000_9E05);
      wreg(ADDR_AUX_SELECT, 32'h0000_0503);
      wreg(ADDR_CTRL, 32'h0000_0002);
      for (int p = 0; p < 4; p++) begin
         pulse();
         outs();
         rchk(ADDR_STATUS);
      end
      wreg(ADDR_CTRL, 32'h0000_0000);
      pulse();
      outs();
      $display("test alternate finished");
      for (int k = 0; k < 4; k++) begin
         d = (k == 3) ? $urandom_range(9, 2) : k * 3;
         wreg(ADDR_CLOCK_SAMPLE, d);
         settle();
         tickchk(d);
      end
      wreg(ADDR_CLOCK_SAMPLE, 32'h0000_8002);
      settle();
      tickchk(-1);
      $display("test clock finished");
      // Reset again mid-run: every field must return to zero
      @(posedge mclk);
      rst <= 1'b1;
      foreach (regs[i]) regs[i] = 0;
      phaseB = 0;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      settle();
      outs();
      for (int a = 0; a <= 32; a += 4) rchk(8'(a));
      tickchk(0);
      $display("test second reset finished");
      final_report();
   end
endmodule
